//--- verilog/main_clock_controller.sv
// Purpose: main clock source select, prescaler, oscillator control
// Assumes: oscillator lines arrive asynchronously; requests are local
// Notes:   index 0 fast rc, 1 slow rc, 2 external clock pin
// Notes on behaviour
// - unrequested, unselected oscillator without run-in-standby is off
// - run-in-standby keeps an oscillator running except in power down
// - run-in-standby removes analog start-up on a later request
// - main clock always runs in active and idle modes
// - in standby main clock runs only if requested or run-in-standby
// - power down stops main clock after nvm operations finish
// - switch to external clock waits for enough edges on the first request only
// - pending external switch ignores new selections until the switch completes
// - switch pending flag set while a source change is in progress
// - status flags show each requested source running and stable
// - peripheral clock is main clock divided by 1 up to 64
// - reset selects fast rc with division by 6
// - fast rc center frequency 16 or 20 MHz from fuse
// - fast rc trims are loaded from fuses at reset
// - calibration lock fuse blocks calibration writes
// - lock bit with fast rc as main source blocks calibration writes
// - fast rc gated after analog start-up plus 4 cycles
// - slow rc yields a 1 kHz tick for rtc, watchdog and bod
// - slow rc output after start-up plus 4 cycles
// - external request configures pin, 2 cycle start on first request
// - protected registers change only within the key write window
// - source codes 0 fast, 1 slow, 3 external, 2 reserved
// - prescaler disabled passes clock; codes select fixed ratios
// - lock bit freezes source and prescaler until reset, calibration only with fast rc as main source
`timescale 1ns/1ps
`include "clkctrl_params.svh"
module main_clock_controller (
   input  wire logic                   sys_clk_in,
   input  wire logic                   rst_n_in,
   input  wire clkctrl_pkg::avs_req_s  avs_in,
   output logic [31:0]                 avs_readdata_out,
   output logic                        avs_waitrequest_out,
   input  wire logic [2:0]             osc_in,
   input  wire logic [2:0]             periph_req_in,
   input  wire logic                   main_req_in,
   input  wire clkctrl_pkg::sleep_mode_e sleep_mode_in,
   input  wire logic                   nvm_busy_in,
   input  wire clkctrl_pkg::fuse_s     fuse_in,
   output logic [2:0]                  osc_enable_out,
   output logic                        main_clock_out,
   output logic                        peripheral_clock_out,
   output logic                        tick_1k_out,
   output logic                        freq_select_out,
   output logic [5:0]                  freq_trim_out,
   output logic [3:0]                  temp_slope_trim_out,
   output logic                        switch_pending_out
);
   import clkctrl_pkg::*;

   localparam logic [15:0] ANA_CYC [3] = '{16'(`FAST_STARTUP_CYC),
      16'(`SLOW_STARTUP_CYC), 16'h0};
   localparam logic [2:0]  GATE_EDGES [3] = '{`FAST_GATE_EDGES,
      `SLOW_GATE_EDGES, `EXT_GATE_EDGES};

   function automatic logic [1:0] src_idx(input clk_src_e s);
      src_idx = (s == SRC_EXT) ? 2'h2 : s;
   endfunction

   function automatic logic [6:0] div_factor(input logic [3:0] d);
      case (d)
         4'h0:    div_factor = 7'd2;
         4'h1:    div_factor = 7'd4;
         4'h2:    div_factor = 7'd8;
         4'h3:    div_factor = 7'd16;
         4'h4:    div_factor = 7'd32;
         4'h5:    div_factor = 7'd64;
         4'h8:    div_factor = 7'd6;
         4'h9:    div_factor = 7'd10;
         4'ha:    div_factor = 7'd12;
         4'hb:    div_factor = 7'd24;
         4'hc:    div_factor = 7'd48;
         default: div_factor = 7'd2;
      endcase
   endfunction

   logic [2:0]    sync1_reg, sync2_reg, sync3_reg, rise;
   logic [2:0]    osc_on, rsb_warm, stable_reg, rsb;
   logic [15:0]   ana_cnt_reg [3];
   logic [2:0]    edge_cnt_reg [3];
   logic          ext_started_reg;
   clk_src_e      sel_reg, active_src_reg;
   switch_state_e state_reg;
   logic          hold_low_reg, main_gate_reg, main_clk_reg;
   logic          main_need, cur_level, main_level_next, main_rise;
   logic [3:0]    prescale_division_reg;
   logic          pen_reg, lock_en_reg, rsb_fast_reg, rsb_slow_reg;
   logic [5:0]    freq_trim_reg, per_cnt_reg, half, tick_cnt_reg;
   logic [3:0]    temp_trim_reg;
   logic [6:0]    divf;
   logic          freq_sel_reg, calib_lock_reg, fuse_loaded_reg;
   logic          per_toggle_reg, per_clk_reg, tick_reg;
   logic          ack_reg, done, wr_acc, prot_ok, calib_block, accept_sel;
   logic [2:0]    win_reg;
   logic [5:0]    idx;
   logic [7:0]    wd;
   logic [31:0]   rd, readdata_reg;

   assign idx = avs_in.address[7:2];
   assign wd  = avs_in.writedata[7:0];
   assign done = (avs_in.read | avs_in.write) & ack_reg;
   assign wr_acc = avs_in.write & ack_reg & avs_in.byteenable[0];
   assign prot_ok = wr_acc & (win_reg != 3'h0);
   assign avs_waitrequest_out = (avs_in.read | avs_in.write) & ~ack_reg;
   assign avs_readdata_out = readdata_reg;

   // main clock demand per sleep mode
   always_comb begin
      case (sleep_mode_in)
         SLP_ACTIVE, SLP_IDLE: main_need = 1'b1;
         SLP_STANDBY: main_need = main_req_in | rsb[src_idx(active_src_reg)];
         default: main_need = nvm_busy_in;
      endcase
   end

   assign rsb = {1'b0, rsb_slow_reg, rsb_fast_reg};

   generate
      for (genvar i = 0; i < 3; i++) begin : gen_src
         assign rise[i] = sync2_reg[i] & ~sync3_reg[i];
         assign osc_on[i] = periph_req_in[i]
            | (src_idx(active_src_reg) == 2'(i) & main_need)
            | (state_reg != SW_IDLE & src_idx(sel_reg) == 2'(i));
         assign rsb_warm[i] = rsb[i] & (sleep_mode_in != SLP_PDOWN);
         assign osc_enable_out[i] = osc_on[i] | rsb_warm[i];
         always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               ana_cnt_reg[i]  <= 16'h0;
               edge_cnt_reg[i] <= 3'h0;
               stable_reg[i]   <= 1'b0;
            end else if (!osc_on[i]) begin
               ana_cnt_reg[i]  <= 16'h0;
               edge_cnt_reg[i] <= 3'h0;
               stable_reg[i]   <= 1'b0;
            end else if (!stable_reg[i]) begin
               if (ana_cnt_reg[i] < ANA_CYC[i] && !rsb_warm[i]) begin
                  ana_cnt_reg[i] <= ana_cnt_reg[i] + 16'h1;
               end else if (edge_cnt_reg[i] >= GATE_EDGES[i]
                  || (i == 2 && ext_started_reg)) begin
                  stable_reg[i] <= 1'b1;
               end else if (rise[i]) begin
                  edge_cnt_reg[i] <= edge_cnt_reg[i] + 3'h1;
               end
            end
         end
      end
   endgenerate

   // two-stage synchronisers plus edge history
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_reg <= 3'h0;
         sync2_reg <= 3'h0;
         sync3_reg <= 3'h0;
      end else begin
         sync1_reg <= osc_in;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   // first external start seen, later requests start at once
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_started_reg <= 1'b0;
      end else if (stable_reg[2]) begin
         ext_started_reg <= 1'b1;
      end
   end

   // fuse capture on the first edge after reset release
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fuse_loaded_reg <= 1'b0;
         freq_sel_reg    <= 1'b0;
         calib_lock_reg  <= 1'b0;
         freq_trim_reg   <= 6'h0;
         temp_trim_reg   <= 4'h0;
      end else if (!fuse_loaded_reg) begin
         fuse_loaded_reg <= 1'b1;
         freq_sel_reg    <= fuse_in.freq_select;
         calib_lock_reg  <= fuse_in.calib_lock;
         freq_trim_reg   <= fuse_in.freq_trim;
         temp_trim_reg   <= fuse_in.temp_slope_trim;
      end else if (prot_ok && !calib_block) begin
         if (idx == `IDX_FAST_CALIB_A) begin
            freq_trim_reg <= wd[5:0];
         end else if (idx == `IDX_FAST_CALIB_B) begin
            temp_trim_reg <= wd[3:0];
         end
      end
   end

   assign calib_block = calib_lock_reg
      | (active_src_reg == SRC_FAST & lock_en_reg);

   // key window counts completed bus transfers
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         win_reg <= 3'h0;
      end else if (wr_acc && idx == `IDX_PROTECT_KEY && wd == `PROTECT_KEY) begin
         win_reg <= `PROTECT_WINDOW;
      end else if (prot_ok && idx != `IDX_PROTECT_KEY) begin
         win_reg <= 3'h0;
      end else if (done && win_reg != 3'h0) begin
         win_reg <= win_reg - 3'h1;
      end
   end

   assign accept_sel = prot_ok && idx == `IDX_MAIN_CTRL_A && !lock_en_reg
      && wd[1:0] != 2'h2
      && (state_reg == SW_IDLE || (state_reg == SW_WAIT && sel_reg != SRC_EXT));

   // control registers
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_reg      <= SRC_FAST;
         prescale_division_reg     <= `RST_PRESCALE_DIVISION;
         pen_reg      <= `RST_PEN;
         lock_en_reg  <= 1'b0;
         rsb_fast_reg <= 1'b0;
         rsb_slow_reg <= 1'b0;
      end else begin
         if (accept_sel) begin
            sel_reg <= clk_src_e'(wd[1:0]);
         end
         if (prot_ok && !lock_en_reg) begin
            if (idx == `IDX_MAIN_CTRL_B) begin
               prescale_division_reg <= wd[4:1];
               pen_reg  <= wd[0];
            end else if (idx == `IDX_MAIN_LOCK && wd[0]) begin
               lock_en_reg <= 1'b1;
            end
         end
         if (prot_ok && idx == `IDX_FAST_CTRL_A) begin
            rsb_fast_reg <= wd[`POS_RUN_STANDBY];
         end
         if (prot_ok && idx == `IDX_SLOW_CTRL_A) begin
            rsb_slow_reg <= wd[`POS_RUN_STANDBY];
         end
      end
   end

   // source switch sequence
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg      <= SW_IDLE;
         active_src_reg <= SRC_FAST;
         hold_low_reg   <= 1'b0;
      end else begin
         case (state_reg)
            SW_IDLE: begin
               if (sel_reg != active_src_reg) begin
                  state_reg <= SW_WAIT;
               end
            end
            SW_WAIT: begin
               if (sel_reg == active_src_reg) begin
                  state_reg <= SW_IDLE;
               end else if (stable_reg[src_idx(sel_reg)]) begin
                  state_reg <= SW_HAND;
               end
            end
            SW_HAND: begin
               if (!sync2_reg[src_idx(active_src_reg)]) begin
                  hold_low_reg <= 1'b1;
               end
               if (hold_low_reg && !sync2_reg[src_idx(sel_reg)]) begin
                  active_src_reg <= sel_reg;
                  hold_low_reg   <= 1'b0;
                  state_reg      <= SW_IDLE;
               end
            end
            default: state_reg <= SW_IDLE;
         endcase
      end
   end

   assign switch_pending_out = (state_reg != SW_IDLE);
   assign cur_level = sync2_reg[src_idx(active_src_reg)] & ~hold_low_reg;
   assign main_level_next = cur_level & main_gate_reg;
   assign main_rise = main_level_next & ~main_clk_reg;
   assign divf = div_factor(prescale_division_reg);
   assign half = divf[6:1];

   // main clock gate moves only while the source is low
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         main_gate_reg <= 1'b0;
         main_clk_reg  <= 1'b0;
      end else begin
         if (!cur_level) begin
            main_gate_reg <= main_need & stable_reg[src_idx(active_src_reg)];
         end
         main_clk_reg <= main_level_next;
      end
   end

   // prescaler
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         per_cnt_reg    <= 6'h0;
         per_toggle_reg <= 1'b0;
         per_clk_reg    <= 1'b0;
      end else begin
         if (main_rise) begin
            if (per_cnt_reg >= half - 6'h1) begin
               per_cnt_reg    <= 6'h0;
               per_toggle_reg <= ~per_toggle_reg;
            end else begin
               per_cnt_reg <= per_cnt_reg + 6'h1;
            end
         end
         per_clk_reg <= pen_reg ? per_toggle_reg : main_clk_reg;
      end
   end

   // 1 kHz tick from slow rc edges
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_cnt_reg <= 6'h0;
         tick_reg     <= 1'b0;
      end else begin
         tick_reg <= 1'b0;
         if (stable_reg[1] && rise[1]) begin
            if (tick_cnt_reg == `SLOW_TICK_DIV - 6'h1) begin
               tick_cnt_reg <= 6'h0;
               tick_reg     <= 1'b1;
            end else begin
               tick_cnt_reg <= tick_cnt_reg + 6'h1;
            end
         end
      end
   end

   // register read mux
   always_comb begin
      rd = 32'h0;
      if (idx == `IDX_MAIN_CTRL_A) begin
         rd[1:0] = sel_reg;
      end else if (idx == `IDX_MAIN_CTRL_B) begin
         rd[4:0] = {prescale_division_reg, pen_reg};
      end else if (idx == `IDX_MAIN_LOCK) begin
         rd[0] = lock_en_reg;
      end else if (idx == `IDX_MAIN_STATUS) begin
         rd[`POS_EXT_STARTED] = stable_reg[2];
         rd[`POS_SLOW_STABLE] = stable_reg[1];
         rd[`POS_FAST_STABLE] = stable_reg[0];
         rd[`POS_SWITCH_PEND] = switch_pending_out;
      end else if (idx == `IDX_FAST_CTRL_A) begin
         rd[`POS_RUN_STANDBY] = rsb_fast_reg;
      end else if (idx == `IDX_FAST_CALIB_A) begin
         rd[5:0] = freq_trim_reg;
      end else if (idx == `IDX_FAST_CALIB_B) begin
         rd[`POS_CALIB_LOCK] = calib_lock_reg;
         rd[3:0] = temp_trim_reg;
      end else if (idx == `IDX_SLOW_CTRL_A) begin
         rd[`POS_RUN_STANDBY] = rsb_slow_reg;
      end
   end

   // bus answer one cycle after the request
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_reg      <= 1'b0;
         readdata_reg <= 32'h0;
      end else begin
         ack_reg <= (avs_in.read | avs_in.write) & ~ack_reg;
         if (avs_in.read && !ack_reg) begin
            readdata_reg <= rd;
         end
      end
   end

   assign main_clock_out       = main_clk_reg;
   assign peripheral_clock_out = per_clk_reg;
   assign tick_1k_out          = tick_reg;
   assign freq_select_out      = freq_sel_reg;
   assign freq_trim_out        = freq_trim_reg;
   assign temp_slope_trim_out  = temp_trim_reg;

   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   a_idle_off: assert property (
      !periph_req_in[1] && active_src_reg != SRC_SLOW && !rsb_slow_reg
      && sel_reg != SRC_SLOW |-> !osc_enable_out[1])
      else $error("slow rc on without cause");
   a_rsb_keep: assert property (
      rsb_fast_reg && sleep_mode_in != SLP_PDOWN |-> osc_enable_out[0])
      else $error("run in standby did not keep fast rc on");
   a_warm_skip: assert property (
      osc_on[0] && rsb_warm[0] |=> $stable(ana_cnt_reg[0]))
      else $error("analog start-up counted while warm");
   a_pd_nvm: assert property (
      sleep_mode_in == SLP_PDOWN && nvm_busy_in && main_gate_reg
      |=> main_gate_reg)
      else $error("main clock stopped during nvm operation");
   a_ext_freeze: assert property (
      state_reg != SW_IDLE && sel_reg == SRC_EXT |=> sel_reg == SRC_EXT)
      else $error("pending external switch was retargeted");
   a_pend_done: assert property (
      $fell(switch_pending_out) |-> active_src_reg == sel_reg)
      else $error("pending cleared before handover");
   a_calib_fuse: assert property (
      calib_lock_reg && fuse_loaded_reg |=> $stable(freq_trim_reg))
      else $error("calibration changed under fuse lock");
   a_lock_freeze: assert property (
      lock_en_reg |=> $stable(prescale_division_reg) && $stable(pen_reg)
      && $stable(lock_en_reg))
      else $error("locked prescaler changed");
   a_prot_ignore: assert property (
      wr_acc && win_reg == 3'h0 && idx == `IDX_MAIN_CTRL_B
      |=> $stable(prescale_division_reg) && $stable(pen_reg))
      else $error("unprotected write took effect");
   a_hand_low: assert property (
      hold_low_reg |=> !main_clk_reg)
      else $error("main clock high during handover hold");
   a_tick_pulse: assert property (
      tick_reg |=> !tick_reg)
      else $error("tick longer than one cycle");

   c_switch_ext: cover property (state_reg == SW_HAND && sel_reg == SRC_EXT);
   c_switch_slow: cover property ($fell(switch_pending_out)
      && active_src_reg == SRC_SLOW);
   c_lock_set: cover property ($rose(lock_en_reg));
   c_tick: cover property (tick_reg);
endmodule

//--- verilog/clkctrl_params.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 200 MHz system clock, register index = byte address / 4
// Notes:   included by the clock controller and its bench
`ifndef CLKCTRL_PARAMS_SVH
`define CLKCTRL_PARAMS_SVH
`define IDX_MAIN_CTRL_A   6'h00
`define IDX_MAIN_CTRL_B   6'h01
`define IDX_MAIN_LOCK     6'h02
`define IDX_MAIN_STATUS   6'h03
`define IDX_FAST_CTRL_A   6'h10
`define IDX_FAST_CALIB_A  6'h11
`define IDX_FAST_CALIB_B  6'h12
`define IDX_SLOW_CTRL_A   6'h18
`define IDX_PROTECT_KEY   6'h1f
`define RST_PRESCALE_DIVISION          4'h8
`define RST_PEN           1'b1
`define POS_RUN_STANDBY   1
`define POS_CALIB_LOCK    7
`define POS_EXT_STARTED   7
`define POS_SLOW_STABLE   5
`define POS_FAST_STABLE   4
`define POS_SWITCH_PEND   0
`define SYS_CLK_MHZ       200
`define FAST_STARTUP_NS   1000
`define SLOW_STARTUP_NS   2000
`define FAST_STARTUP_CYC  ((`FAST_STARTUP_NS * `SYS_CLK_MHZ + 999) / 1000)
`define SLOW_STARTUP_CYC  ((`SLOW_STARTUP_NS * `SYS_CLK_MHZ + 999) / 1000)
`define FAST_GATE_EDGES   3'h4
`define SLOW_GATE_EDGES   3'h4
`define EXT_GATE_EDGES    3'h2
`define SLOW_TICK_DIV     6'h20
`define PROTECT_WINDOW    3'h4
`define PROTECT_KEY       8'h5a
`endif

//--- verilog/clkctrl_pkg.sv
// Purpose: types shared by the clock controller and its bench
// Assumes: nothing
// Notes:   source codes follow the main source select field
package clkctrl_pkg;
   typedef enum logic [1:0] {
      SRC_FAST = 2'h0,
      SRC_SLOW = 2'h1,
      SRC_EXT  = 2'h3
   } clk_src_e;
   typedef enum logic [1:0] {
      SLP_ACTIVE  = 2'h0,
      SLP_IDLE    = 2'h1,
      SLP_STANDBY = 2'h2,
      SLP_PDOWN   = 2'h3
   } sleep_mode_e;
   typedef enum logic [2:0] {
      SW_IDLE = 3'b001,
      SW_WAIT = 3'b010,
      SW_HAND = 3'b100
   } switch_state_e;
   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } avs_req_s;
   typedef struct packed {
      logic       freq_select;
      logic       calib_lock;
      logic [5:0] freq_trim;
      logic [3:0] temp_slope_trim;
   } fuse_s;
endpackage

//--- test/osc_model.sv
// Purpose: oscillator lines seen by the clock controller
// Assumes: fast rc 40 ns, slow rc 60 ns, external pin 34 ns period
// Notes:   a line stands low while its source is disabled or stalled
`timescale 1ns/1ps
module osc_model (
   input  wire logic [2:0] en_in,
   input  wire logic       ext_run_in,
   output logic [2:0]      osc_out
);
   logic fast_reg;
   logic slow_reg;
   logic ext_reg;
   initial begin
      fast_reg = 1'b0;
      slow_reg = 1'b0;
      ext_reg  = 1'b0;
   end
   always #20 fast_reg = en_in[0] ? ~fast_reg : 1'b0;
   always #30 slow_reg = en_in[1] ? ~slow_reg : 1'b0;
   // external pin only toggles when the bench lets it run
   always #17 ext_reg = (en_in[2] && ext_run_in) ? ~ext_reg : 1'b0;
   assign osc_out = {ext_reg, slow_reg, fast_reg};
endmodule

//--- test/test_main_clock_controller.sv
// Purpose: self-checking bench for the main clock controller
// Assumes: 200 MHz system clock, oscillators from osc_model
// Notes:   one task per scenario
`timescale 1ns/1ps
`include "clkctrl_params.svh"
module test_main_clock_controller;
   import clkctrl_pkg::*;
   logic sys_clk_in, rst_n_in, nvm_busy, main_req, ext_run, wait_r;
   logic mclk, pclk, fsel, pend, mq, pq, tick;
   avs_req_s req;
   sleep_mode_e slp;
   fuse_s fuse;
   logic [31:0] rdata;
   logic [2:0] osc, en, preq;
   logic [5:0] trim;
   logic [3:0] tslope;
   logic [7:0] q;
   int n_fail, samples_checked, cycles, n, cnt, per, tgap, tlast;
   logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8,
      4'h9, 4'ha, 4'hb, 4'hc};
   int divs [11] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48};
   main_clock_controller i_main_clock_controller (.sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in), .avs_in(req), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wait_r), .osc_in(osc), .periph_req_in(preq),
      .main_req_in(main_req), .sleep_mode_in(slp), .nvm_busy_in(nvm_busy),
      .fuse_in(fuse), .osc_enable_out(en), .main_clock_out(mclk),
      .peripheral_clock_out(pclk), .tick_1k_out(tick), .freq_select_out(fsel),
      .freq_trim_out(trim), .temp_slope_trim_out(tslope),
      .switch_pending_out(pend));
   osc_model i_osc_model (.en_in(en), .ext_run_in(ext_run), .osc_out(osc));
   initial begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end
   // main clock rising edges between two peripheral clock rising edges
   always @(posedge sys_clk_in) begin
      mq <= mclk;
      pq <= pclk;
      cycles <= cycles + 1;
      if (tick) begin
         tgap <= cycles - tlast;
         tlast <= cycles;
      end
      if (pclk && !pq) begin
         per <= cnt;
         cnt <= (mclk && !mq) ? 1 : 0;
      end else if (mclk && !mq) begin
         cnt <= cnt + 1;
      end
      if (cycles == 60000) begin
         n_fail = n_fail + 1;
         end_of_test();
      end
   end
   task end_of_test;
      if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
      @(posedge sys_clk_in);
      req.read <= ~wr;
      req.write <= wr;
      req.address <= {idx, 2'b00};
      req.byteenable <= 4'h1;
      req.writedata <= {24'h0, d};
      @(posedge sys_clk_in);
      while (wait_r !== 1'b0) @(posedge sys_clk_in);
      q = rdata[7:0];
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask
   task pwr(input logic [5:0] idx, input logic [7:0] d);
      bus(1'b1, `IDX_PROTECT_KEY, `PROTECT_KEY);
      bus(1'b1, idx, d);
   endtask
   task ratio(output int r);
      repeat (3) @(posedge pclk);
      repeat (2) @(posedge sys_clk_in);
      r = per;
   endtask
   task toggles(output int t);
      t = 0;
      repeat (40) begin
         @(posedge sys_clk_in);
         if (mclk !== mq) t++;
      end
   endtask
   task wait_pend(input logic v, input int lim);
      n = 0;
      while (pend !== v && n < lim) begin
         @(posedge sys_clk_in);
         n++;
      end
   endtask
   task do_reset;
      rst_n_in <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge sys_clk_in);
   endtask
   task t_reset;
      chk(trim, fuse.freq_trim);
      chk(tslope, fuse.temp_slope_trim);
      chk(fsel, fuse.freq_select);
      bus(1'b0, `IDX_MAIN_CTRL_B, 8'h00);
      chk(q, {3'h0, `RST_PRESCALE_DIVISION, `RST_PEN});
      bus(1'b0, `IDX_MAIN_CTRL_A, 8'h00);
      chk(q, 8'h00);
      ratio(n);
      chk(n, 6);
   endtask
   task t_protect;
      bus(1'b1, `IDX_MAIN_CTRL_B, 8'h03);
      bus(1'b0, `IDX_MAIN_CTRL_B, 8'h00);
      chk(q, 8'h11);
      bus(1'b1, `IDX_FAST_CALIB_A, 8'h11);
      @(posedge sys_clk_in);
      chk(trim, 6'h2b);
      bus(1'b1, `IDX_PROTECT_KEY, `PROTECT_KEY);
      repeat (4) bus(1'b0, `IDX_MAIN_STATUS, 8'h00);
      bus(1'b1, `IDX_FAST_CALIB_A, 8'h11);
      @(posedge sys_clk_in);
      chk(trim, 6'h2b);
      pwr(`IDX_MAIN_CTRL_B, 8'h0b);
      pwr(`IDX_FAST_CALIB_A, 8'h15);
      repeat (3) @(posedge sys_clk_in);
      chk(trim, 6'h15);
      pwr(`IDX_MAIN_CTRL_B, 8'h11);
   endtask
   task t_prescale;
      for (int i = 0; i < 11; i++) begin
         pwr(`IDX_MAIN_CTRL_B, {3'h0, codes[i], 1'b1});
         ratio(n);
         chk(n, divs[i]);
      end
      pwr(`IDX_MAIN_CTRL_B, 8'h00);
      ratio(n);
      chk(n, 1);
   endtask
   task t_sleep;
      nvm_busy <= 1'b1;
      slp <= SLP_PDOWN;
      repeat (20) @(posedge sys_clk_in);
      toggles(n);
      chk(n != 0, 1'b1);
      nvm_busy <= 1'b0;
      repeat (20) @(posedge sys_clk_in);
      toggles(n);
      chk(n, 0);
      slp <= SLP_STANDBY;
      repeat (300) @(posedge sys_clk_in);
      toggles(n);
      chk(n, 0);
      main_req <= 1'b1;
      repeat (300) @(posedge sys_clk_in);
      toggles(n);
      chk(n != 0, 1'b1);
      pwr(`IDX_FAST_CTRL_A, 8'h02);
      main_req <= 1'b0;
      repeat (300) @(posedge sys_clk_in);
      toggles(n);
      chk(n != 0, 1'b1);
      slp <= SLP_IDLE;
      pwr(`IDX_FAST_CTRL_A, 8'h00);
      repeat (300) @(posedge sys_clk_in);
      toggles(n);
      chk(n != 0, 1'b1);
   endtask
   task t_switch;
      pwr(`IDX_MAIN_CTRL_A, 8'h01);
      wait_pend(1'b1, 5);
      chk(pend, 1'b1);
      wait_pend(1'b0, 3000);
      chk(pend, 1'b0);
      bus(1'b0, `IDX_MAIN_STATUS, 8'h00);
      chk(q & 8'hb1, 8'h20);
      chk(en[0], 1'b0);
      repeat (900) @(posedge sys_clk_in);
      chk(tgap, 384);
      ext_run <= 1'b0;
      pwr(`IDX_MAIN_CTRL_A, 8'h03);
      wait_pend(1'b1, 5);
      repeat (300) @(posedge sys_clk_in);
      chk({en[2], pend}, 2'b11);
      pwr(`IDX_MAIN_CTRL_A, 8'h00);
      ext_run <= 1'b1;
      wait_pend(1'b0, 2000);
      chk(pend, 1'b0);
      bus(1'b0, `IDX_MAIN_CTRL_A, 8'h00);
      chk(q[1:0], 2'h3);
      bus(1'b0, `IDX_MAIN_STATUS, 8'h00);
      chk(q[7], 1'b1);
   endtask
   task t_lock;
      fuse.calib_lock <= 1'b1;
      do_reset();
      pwr(`IDX_FAST_CALIB_A, 8'h05);
      bus(1'b0, `IDX_FAST_CALIB_B, 8'h00);
      chk(q, 8'h89);
      chk(trim, 6'h2b);
      fuse.calib_lock <= 1'b0;
      do_reset();
      chk(trim, 6'h2b);
      pwr(`IDX_MAIN_LOCK, 8'h01);
      pwr(`IDX_MAIN_CTRL_B, 8'h03);
      bus(1'b0, `IDX_MAIN_CTRL_B, 8'h00);
      chk(q, 8'h11);
      pwr(`IDX_FAST_CALIB_A, 8'h05);
      repeat (3) @(posedge sys_clk_in);
      chk(trim, 6'h2b);
   endtask
   initial begin
      n_fail = 0;
      samples_checked = 0;
      cycles = 0;
      cnt = 0;
      per = 0;
      tgap = 0;
      tlast = 0;
      rst_n_in = 1'b0;
      req = '0;
      preq = 3'h0;
      main_req = 1'b0;
      nvm_busy = 1'b0;
      ext_run = 1'b1;
      slp = SLP_ACTIVE;
      fuse = '{freq_select: 1'b1, calib_lock: 1'b0, freq_trim: 6'h2b,
               temp_slope_trim: 4'h9};
      do_reset();
      t_reset();
      t_protect();
      t_prescale();
      t_sleep();
      slp <= SLP_ACTIVE;
      t_switch();
      t_lock();
      end_of_test();
   end
endmodule
